// ===== hw/pdv_pkg.sv
// Package for the panel detect / common voltage limit register bank.
// Assumes a single 100 MHz clock and an internal byte-wide register port.
package pdv_pkg;

	// Register addresses on the internal port
	localparam logic [7:0] ADDR_THRESHOLD = 8'h11;
	localparam logic [7:0] ADDR_DELAY = 8'h12;
	localparam logic [7:0] ADDR_COMMON_VOLTAGE_UPPER_LIMIT_LIMIT = 8'h13;
	localparam logic [7:0] ADDR_CONTROL = 8'hFF;

	// Field layout
	localparam int FIELD_W = 4;
	localparam int CTRL_TRIGGER_BIT = 7;
	localparam int CTRL_READ_SRC_BIT = 0;
	localparam logic [3:0] UPPER_ZERO = 4'h0;
	localparam logic [5:0] CTRL_GAP_ZERO = 6'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// Power-on default codes
	localparam logic [3:0] THRESHOLD_RESET = 4'h0;
	localparam logic [3:0] DELAY_RESET = 4'h2;
	localparam logic [3:0] COMMON_VOLTAGE_UPPER_LIMIT_LIMIT_RESET = 4'h7;

	// Code decoding
	localparam logic [3:0] THR_UNDERVOLTAGE_LOCKOUT_CODE = 4'h0;
	localparam logic [3:0] THR_TOP_CODE = 4'hB;
	localparam logic [4:0] THR_BASE_DV = 5'h13;
	localparam logic [4:0] THR_MAX_DV = 5'h1E;
	localparam logic [6:0] DELAY_STEP_MS = 7'h05;
	localparam logic [5:0] COMMON_VOLTAGE_UPPER_LIMIT_BASE_TENTHS = 6'h19;

	// Nonvolatile copy timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int NV_PROGRAM_NS = 160;
	localparam int NV_PROGRAM_CYCLES = (NV_PROGRAM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NV_CNT_W = 8;
	localparam logic [7:0] NV_LAST_COUNT = 8'(NV_PROGRAM_CYCLES - 1);

	// Stored codes of the three registers
	typedef struct packed {
		logic [3:0] threshold;
		logic [3:0] delay;
		logic [3:0] common_voltage_upper_limit_limit;
	} pdv_fields_s;

	// Decoded values for the analog consumers
	typedef struct packed {
		logic undervoltage_lockout_select;
		logic [4:0] threshold_dv;
		logic [6:0] delay_ms;
		logic [5:0] common_voltage_upper_limit_tenths;
	} pdv_levels_s;

	typedef enum logic [0:0] {
		NV_IDLE,
		NV_PROGRAM
	} pdv_nv_state_e;

endpackage

// ===== hw/pdv_field_reg.sv
// One 4-bit field with a volatile working copy and a nonvolatile copy.
// Assumes write and copy strobes come from logic on the same clock.
`timescale 1ns/1ps

module pdv_field_reg #(
	parameter logic [3:0] RESET_CODE = 4'h0
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// Control
	input wire logic wr_en,
	input wire logic [3:0] wdata,
	input wire logic nv_copy,
	// Stored codes
	output logic [3:0] vol_code,
	output logic [3:0] nv_code
);

	logic [3:0] next_vol_code;
	logic [3:0] next_nv_code;

	// Next values: write lands in the volatile copy, copy snapshots it
	always_comb begin
		next_vol_code = vol_code;
		next_nv_code = nv_code;
		if (wr_en) begin
			next_vol_code = wdata;
		end
		if (nv_copy) begin
			next_nv_code = vol_code;
		end
	end

	// Both copies load the power-on default
	always_ff @(posedge clk) begin
		if (reset) begin
			vol_code <= RESET_CODE;
			nv_code <= RESET_CODE;
		end else if (ce) begin
			vol_code <= next_vol_code;
			nv_code <= next_nv_code;
		end
	end

endmodule

// ===== hw/pdv_regs.sv
// Supply-detect threshold, discharge delay and common voltage limit registers.
// Assumes the serial slave drives the register port on the same clock.
//
// Contract
// [R1] The threshold register at 11h can be written and read.
// [R2] The discharge start-up delay register at 12h can be written and read.
// [R3] The common voltage upper-limit register at 13h can be written and read.
// [R4] Bits 7-4 of the three registers ignore writes and read as zero.
// [R5] Threshold code 0 selects undervoltage lockout, 1-B give 2.0-3.0 V, C-F give 3.0 V.
// [R6] The delay code times 5 ms is the start-up delay of the discharge output.
// [R7] The limit code gives (2.5 + 0.1 x code)/8 of the analog supply.
// [R8] Each code is held and presented continuously, updated on the write cycle.
// [R9] A read-source bit picks the volatile (0) or nonvolatile (1) copy for reads.
// [R10] Setting the nonvolatile write bit copies all fields and clears itself when done.
`timescale 1ns/1ps

module pdv_regs (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// Register port from the serial slave
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Codes and decoded levels for the analog side
	output pdv_pkg::pdv_fields_s field_codes,
	output pdv_pkg::pdv_levels_s field_levels,
	// Control state
	output logic read_source_select,
	output logic nonvolatile_write_trigger
);

	pdv_pkg::pdv_fields_s vol;
	pdv_pkg::pdv_fields_s nv;
	logic [3:0] vol_thr;
	logic [3:0] vol_dly;
	logic [3:0] vol_common_voltage_upper_limit;
	logic [3:0] nv_thr;
	logic [3:0] nv_dly;
	logic [3:0] nv_common_voltage_upper_limit;
	pdv_pkg::pdv_levels_s next_levels;
	pdv_pkg::pdv_nv_state_e nv_state;
	pdv_pkg::pdv_nv_state_e next_nv_state;
	logic [7:0] nv_cnt;
	logic [7:0] next_nv_cnt;
	logic next_read_source_select;
	logic next_nonvolatile_write_trigger;
	logic nv_copy;
	logic [7:0] next_rdata;
	logic wr_thr;
	logic wr_dly;
	logic wr_common_voltage_upper_limit;
	logic wr_ctrl;
	logic set_trigger;

	// Address decode, gated by the enable so a frozen block takes nothing
	// [R1] threshold write decode
	assign wr_thr = ce && reg_wr && (reg_addr == pdv_pkg::ADDR_THRESHOLD);
	// [R2] delay write decode
	assign wr_dly = ce && reg_wr && (reg_addr == pdv_pkg::ADDR_DELAY);
	// [R3] limit write decode
	assign wr_common_voltage_upper_limit = ce && reg_wr && (reg_addr == pdv_pkg::ADDR_COMMON_VOLTAGE_UPPER_LIMIT_LIMIT);
	assign wr_ctrl = ce && reg_wr && (reg_addr == pdv_pkg::ADDR_CONTROL);
	assign set_trigger = wr_ctrl && reg_wdata[pdv_pkg::CTRL_TRIGGER_BIT];

	// Field storage; only the low nibble is passed, so upper bits are dropped
	// [R4] upper nibble discarded
	pdv_field_reg #(.RESET_CODE(pdv_pkg::THRESHOLD_RESET)) u_thr (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.wr_en(wr_thr),
		.wdata(reg_wdata[pdv_pkg::FIELD_W-1:0]),
		.nv_copy(nv_copy),
		.vol_code(vol_thr),
		.nv_code(nv_thr)
	);
	pdv_field_reg #(.RESET_CODE(pdv_pkg::DELAY_RESET)) u_dly (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.wr_en(wr_dly),
		.wdata(reg_wdata[pdv_pkg::FIELD_W-1:0]),
		.nv_copy(nv_copy),
		.vol_code(vol_dly),
		.nv_code(nv_dly)
	);
	pdv_field_reg #(.RESET_CODE(pdv_pkg::COMMON_VOLTAGE_UPPER_LIMIT_LIMIT_RESET)) u_common_voltage_upper_limit (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.wr_en(wr_common_voltage_upper_limit),
		.wdata(reg_wdata[pdv_pkg::FIELD_W-1:0]),
		.nv_copy(nv_copy),
		.vol_code(vol_common_voltage_upper_limit),
		.nv_code(nv_common_voltage_upper_limit)
	);

	// Gather the per-field copies; each carrier struct then has a single driver
	assign vol = {vol_thr, vol_dly, vol_common_voltage_upper_limit};
	assign nv = {nv_thr, nv_dly, nv_common_voltage_upper_limit};

	// Working codes go out straight from the field flip-flops
	// [R8] continuous code presentation
	assign field_codes = vol;

	// Decode of each code into the level the analog side needs
	always_comb begin
		next_levels = field_levels;
		// [R5] threshold code mapping
		next_levels.undervoltage_lockout_select = (vol.threshold == pdv_pkg::THR_UNDERVOLTAGE_LOCKOUT_CODE);
		if (vol.threshold == pdv_pkg::THR_UNDERVOLTAGE_LOCKOUT_CODE) begin
			next_levels.threshold_dv = 5'h00;
		end else if (vol.threshold > pdv_pkg::THR_TOP_CODE) begin
			next_levels.threshold_dv = pdv_pkg::THR_MAX_DV; // Saturates at 3.0 V
		end else begin
			next_levels.threshold_dv = pdv_pkg::THR_BASE_DV + 5'(vol.threshold);
		end
		// [R6] delay in 5 ms steps
		next_levels.delay_ms = 7'(vol.delay) * pdv_pkg::DELAY_STEP_MS;
		// [R7] limit in tenths of eighths
		next_levels.common_voltage_upper_limit_tenths = pdv_pkg::COMMON_VOLTAGE_UPPER_LIMIT_BASE_TENTHS + 6'(vol.common_voltage_upper_limit_limit);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			field_levels <= '0;
		end else if (ce) begin
			field_levels <= next_levels;
		end
	end

	// Control bits and the nonvolatile copy sequence
	// Writing 0 to the trigger while programming does not abort: a half copy
	// would leave the stored set inconsistent.
	always_comb begin
		next_nv_state = nv_state;
		next_nv_cnt = nv_cnt;
		next_read_source_select = read_source_select;
		next_nonvolatile_write_trigger = nonvolatile_write_trigger;
		nv_copy = 1'b0;
		// [R9] read source bit store
		if (wr_ctrl) begin
			next_read_source_select = reg_wdata[pdv_pkg::CTRL_READ_SRC_BIT];
		end
		case (nv_state)
			pdv_pkg::NV_IDLE: begin
				if (set_trigger) begin
					next_nv_state = pdv_pkg::NV_PROGRAM;
					next_nonvolatile_write_trigger = 1'b1;
					next_nv_cnt = 8'h00;
				end
			end
			pdv_pkg::NV_PROGRAM: begin
				if (nv_cnt == pdv_pkg::NV_LAST_COUNT) begin
					// [R10] copy then self clear
					nv_copy = ce;
					if (set_trigger) begin
						next_nv_cnt = 8'h00; // New request wins over the clear
					end else begin
						next_nonvolatile_write_trigger = 1'b0;
						next_nv_state = pdv_pkg::NV_IDLE;
					end
				end else begin
					next_nv_cnt = nv_cnt + 8'h01;
				end
			end
			default: begin
				next_nv_state = pdv_pkg::NV_IDLE;
				next_nonvolatile_write_trigger = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			nv_state <= pdv_pkg::NV_IDLE;
			nv_cnt <= 8'h00;
			read_source_select <= 1'b0;
			nonvolatile_write_trigger <= 1'b0;
		end else if (ce) begin
			nv_state <= next_nv_state;
			nv_cnt <= next_nv_cnt;
			read_source_select <= next_read_source_select;
			nonvolatile_write_trigger <= next_nonvolatile_write_trigger;
		end
	end

	// Read data, held until the next read so the slave can shift it out
	always_comb begin
		next_rdata = reg_rdata;
		if (reg_rd) begin
			case (reg_addr)
				// [R9] volatile or stored copy
				pdv_pkg::ADDR_THRESHOLD: begin
					next_rdata = {pdv_pkg::UPPER_ZERO, read_source_select ? nv.threshold : vol.threshold};
				end
				pdv_pkg::ADDR_DELAY: begin
					next_rdata = {pdv_pkg::UPPER_ZERO, read_source_select ? nv.delay : vol.delay};
				end
				pdv_pkg::ADDR_COMMON_VOLTAGE_UPPER_LIMIT_LIMIT: begin
					next_rdata = {pdv_pkg::UPPER_ZERO, read_source_select ? nv.common_voltage_upper_limit_limit : vol.common_voltage_upper_limit_limit};
				end
				pdv_pkg::ADDR_CONTROL: begin
					next_rdata = {nonvolatile_write_trigger, pdv_pkg::CTRL_GAP_ZERO, read_source_select};
				end
				default: begin
					next_rdata = pdv_pkg::UNMAPPED_READ;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (ce) begin
			reg_rdata <= next_rdata;
		end
	end

	// Checks on the stored codes, the read path and the copy sequence
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_thr_write_lands: assert property (wr_thr |=> field_codes.threshold == $past(reg_wdata[3:0])) // [R1]
		else $error("threshold code did not take the written value");
	a_dly_write_lands: assert property (wr_dly |=> field_codes.delay == $past(reg_wdata[3:0])) // [R2]
		else $error("delay code did not take the written value");
	a_common_voltage_upper_limit_write_lands: assert property (wr_common_voltage_upper_limit |=> field_codes.common_voltage_upper_limit_limit == $past(reg_wdata[3:0])) // [R3]
		else $error("limit code did not take the written value");
	a_upper_reads_zero: assert property (ce && reg_rd && reg_addr != pdv_pkg::ADDR_CONTROL |=> reg_rdata[7:4] == 4'h0) // [R4]
		else $error("upper nibble of a field read not zero");
	// Antecedents skip the edge that still ran the reset branch, where levels load zero
	a_thr_level_map: assert property (ce && !reset |=> // [R5]
		field_levels.undervoltage_lockout_select == ($past(vol.threshold) == 4'h0)
		&& (($past(vol.threshold) == 4'h0) || field_levels.threshold_dv ==
		(($past(vol.threshold) > 4'hB) ? 5'h1E : 5'(5'h13 + $past(vol.threshold)))))
		else $error("threshold level does not match code");
	a_delay_level_map: assert property (ce && !reset |=> field_levels.delay_ms == 7'(7'h05 * $past(vol.delay))) // [R6]
		else $error("delay level is not code times five");
	a_common_voltage_upper_limit_level_map: assert property (ce && !reset |=> // [R7]
		field_levels.common_voltage_upper_limit_tenths == 6'(6'h19 + $past(vol.common_voltage_upper_limit_limit)))
		else $error("limit level is not base plus code");
	a_code_holds: assert property (!wr_thr && !wr_dly && !wr_common_voltage_upper_limit |=> $stable(field_codes)) // [R8]
		else $error("code changed without a write");
	a_read_nv_copy: assert property (ce && reg_rd && reg_addr == pdv_pkg::ADDR_THRESHOLD // [R9]
		&& read_source_select |=> reg_rdata[3:0] == $past(nv.threshold))
		else $error("stored copy not returned with read source set");
	a_nv_copy_ends: assert property (ce && nonvolatile_write_trigger && !set_trigger // [R10]
		&& nv_cnt == pdv_pkg::NV_LAST_COUNT |=> !nonvolatile_write_trigger)
		else $error("nonvolatile write bit did not clear after the last count");
	a_nv_count_bound: assert property (nonvolatile_write_trigger |-> nv_cnt <= pdv_pkg::NV_LAST_COUNT) // [R10]
		else $error("copy counter ran past its last count");
	a_nv_copy_takes: assert property (nv_copy |=> nv == $past(vol)) // [R10]
		else $error("stored copy does not match working copy after copy");

	c_thr_write: cover property (wr_thr ##[1:4] reg_rd && reg_addr == pdv_pkg::ADDR_THRESHOLD);
	c_nv_copy_done: cover property ($fell(nonvolatile_write_trigger));
	c_read_nv: cover property (ce && reg_rd && read_source_select);
	c_unmapped_read: cover property (ce && reg_rd && reg_addr == 8'h14);

endmodule

// ===== testbench/pdv_host_model.sv
// Host side of the register port: serial slave issuing single-byte cycles.
// Assumes the bench drives ce and reset; strobes are one-cycle pulses.
`timescale 1ns/1ps

module pdv_host_model (
	// Clock
	input wire logic clk,
	// Register port toward the bank
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata
);
	// Idle values at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end

	// One write byte; released lines show the inverse so stale data is never read as valid
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask

	// One read byte; data is taken by the caller after this edge
	task automatic read(input logic [7:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
	endtask
endmodule

// ===== testbench/tb_pdv_regs.sv
// Self-checking bench for the threshold, delay and limit register bank.
// Assumes pdv_pkg and the design are compiled first; one 100 MHz clock.
`timescale 1ns/1ps

module tb_pdv_regs;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic ce = 1'b1;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	pdv_pkg::pdv_fields_s field_codes;
	pdv_pkg::pdv_levels_s field_levels;
	logic read_source_select;
	logic nonvolatile_write_trigger;
	int err_total = 0;
	int samples_checked = 0;
	logic [7:0] lfsr = 8'h1B;
	int vol[3] = '{0, 2, 7};
	int nvc[3] = '{0, 2, 7};
	int rsrc = 0;

	// Clock
	always #5 clk = ~clk;

	pdv_regs pdv_regs_i (.clk(clk), .reset(reset), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .field_codes(field_codes),
		.field_levels(field_levels), .read_source_select(read_source_select),
		.nonvolatile_write_trigger(nonvolatile_write_trigger));
	pdv_host_model pdv_host_model_i (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata));

	// Shared comparison; case inequality so unknowns never match
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Reference read value from the integer model
	function automatic logic [7:0] exp_rd(input logic [7:0] a);
		if (a >= 8'h11 && a <= 8'h13) begin
			return 8'(rsrc ? nvc[int'(a) - 17] : vol[int'(a) - 17]);
		end
		return (a == 8'hFF) ? 8'(rsrc) : 8'h00;
	endfunction

	function automatic logic [3:0] code_of(input int r);
		return (r == 0) ? field_codes.threshold : (r == 1) ? field_codes.delay : field_codes.common_voltage_upper_limit_limit;
	endfunction

	// Random source for the upper nibble that the bank must drop
	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	// Count cycles while the copy runs; the stored side takes the working side at its end
	task automatic copy_wait(input logic [7:0] exp_len);
		int n;
		n = 0;
		while (n < 40 && nonvolatile_write_trigger === 1'b1) begin
			n++;
			@(posedge clk);
			#1;
		end
		if (n == 40) complete_run_timeout();
		check("copy_len", 8'(n), exp_len);
		check("trig_clr", 8'(nonvolatile_write_trigger), 8'h00);
		nvc = vol;
	endtask

	// Write through the host and update the model; the stored side follows in copy_wait
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		if (a >= 8'h11 && a <= 8'h13) vol[int'(a) - 17] = int'(d[3:0]);
		if (a == 8'hFF) rsrc = int'(d[0]);
		pdv_host_model_i.write(a, d);
		#1;
	endtask

	task automatic rd(input logic [7:0] a);
		pdv_host_model_i.read(a);
		#1;
		check("rdata", reg_rdata, exp_rd(a));
	endtask

	// Main sequence
	initial begin
		int c;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		for (int r = 0; r < 3; r++) rd(8'(17 + r));
		$display("test reset_values done");
		// Every code of every field, random upper nibble that must be dropped
		for (int r = 0; r < 3; r++) begin
			for (c = 0; c < 16; c++) begin
				lfsr = lfsr_next(lfsr);
				wr(8'(17 + r), {lfsr[7:4], 4'(c)});
				check("code", 8'(code_of(r)), 8'(c));
				@(posedge clk);
				#1;
				if (r == 0) begin
					check("undervoltage_lockout", 8'(field_levels.undervoltage_lockout_select), 8'(c == 0));
					check("thr_dv", 8'(field_levels.threshold_dv), 8'(c == 0 ? 0 : c > 11 ? 30 : 19 + c));
				end else if (r == 1) begin
					check("delay_ms", 8'(field_levels.delay_ms), 8'(c * 5));
				end else begin
					check("common_voltage_upper_limit", 8'(field_levels.common_voltage_upper_limit_tenths), 8'(25 + c));
				end
				rd(8'(17 + r));
			end
		end
		$display("test field_codes done");
		// Unmapped neighbours read zero; writes are refused while ce is low
		rd(8'h10);
		rd(8'h14);
		@(posedge clk);
		ce <= 1'b0;
		pdv_host_model_i.write(8'h11, 8'h03);
		pdv_host_model_i.read(8'h12);
		ce <= 1'b1;
		#1;
		check("ce_hold", 8'(field_codes.threshold), 8'(vol[0]));
		check("ce_rd_hold", reg_rdata, 8'h00);
		$display("test unmapped_ce done");
		// Copy to stored side, then change working copy and read both sources
		wr(8'hFF, 8'h80);
		copy_wait(8'h10);
		wr(8'h11, 8'h09);
		wr(8'h13, 8'h0C);
		wr(8'hFF, 8'h01);
		check("rsrc", 8'(read_source_select), 8'h01);
		rd(8'h11);
		rd(8'h13);
		rd(8'hFF);
		wr(8'hFF, 8'h00);
		rd(8'h11);
		$display("test copy_source done");
		// Clearing the trigger mid-copy is ignored; a field write before the end is stored
		wr(8'hFF, 8'h80);
		wr(8'hFF, 8'h00);
		check("trig_hold", 8'(nonvolatile_write_trigger), 8'h01);
		wr(8'h12, 8'h05);
		copy_wait(8'h0C); // two writes of two cycles each already spent
		// A request in the completion cycle restarts the copy
		wr(8'hFF, 8'h81);
		repeat (14) @(posedge clk);
		wr(8'hFF, 8'h81);
		check("trig_restart", 8'(nonvolatile_write_trigger), 8'h01);
		copy_wait(8'h10);
		wr(8'h12, 8'h0A);
		rd(8'h12);
		rd(8'h11);
		$display("test copy_race done");
		// Reset in mid-run restores the power-on codes and clears the control bits
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		vol = '{0, 2, 7};
		nvc = '{0, 2, 7};
		rsrc = 0;
		for (int r = 0; r < 3; r++) rd(8'(17 + r));
		rd(8'hFF);
		check("rst_delay", 8'(field_levels.delay_ms), 8'h0A);
		$display("test mid_reset done");
		complete_run();
	end

	// A copy that never ends counts as a mismatch
	task automatic complete_run_timeout();
		err_total++;
		$display("[ERR] copy_wait expected clear seen timeout");
		complete_run();
	endtask
endmodule
